// *** dp_alarm_cfg.svh ***
// header: offsets, field positions, error codes and timing counts
// assumes: included by bare name from the top module and the testbench
`ifndef DP_ALARM_CFG_SVH
`define DP_ALARM_CFG_SVH

// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_ALARM_SRC 12'h008
`define OFS_ALARM_LO 12'h00c
`define OFS_ALARM_HI 12'h010
`define OFS_REQ 12'h014
`define OFS_REQ_EXEC 12'h018
`define OFS_RESP 12'h01c
`define OFS_SYNC 12'h020

// ------------------------------------------------------------
// alarm block fields
// ------------------------------------------------------------
`define ALARM_BLOCK_LEN 6'h06
`define ALARM_SEL_DEVICE 2'h0
`define ALARM_TYPE_DIAG 7'h01
`define ALARM_ID_ALARM 1'b0
`define ALARM_SEQ_ZERO 5'h00

// ------------------------------------------------------------
// record access figures
// ------------------------------------------------------------
`define IDENT_SLOT 8'h00
`define IDENT_INDEX 8'hff
`define IDENT_EXT_FN 8'h08
`define IDENT_WR_LEN 8'h44
`define IDENT_MAX_REC 8'h04
`define ERR_WRITE_LEN 24'h80b800
`define ERR_EXT_FN 24'h80b600
`define ERR_NO_REQ 24'h80b500
`define ERR_BAD_ADDR 24'h80b000
`define PROC_CYCLES 4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define SYNC_TOL_NS 1000
`define SYNC_TOL_CYCLES (`SYNC_TOL_NS / `CLK_PERIOD_NS)

`endif

// *** dp_alarm_pkg.sv ***
// package: shared types of the alarm and record access block
// assumes: constants come from dp_alarm_cfg.svh
package dp_alarm_pkg;

   // five-byte diagnosis alarm block plus detail byte
   typedef struct packed {
      logic [7:0] detail;
      logic [7:0] specifier;
      logic [7:0] slot;
      logic [7:0] type_id;
      logic [7:0] len_sel;
      logic [7:0] header;
   } alarm_block_t;

   // record request as posted by the master
   typedef struct packed {
      logic [7:0] slot;
      logic [7:0] index;
      logic [7:0] ext_fn;
      logic [7:0] rec_idx;
      logic [7:0] length;
      logic is_write;
   } rec_req_t;

   typedef enum logic [3:0] {
      REC_IDLE = 4'h1,
      REC_BUSY = 4'h2,
      REC_DONE = 4'h4,
      REC_ERR = 4'h8
   } rec_state_t;

endpackage : dp_alarm_pkg

// *** dp_alarm_record.sv ***
// top: diagnosis alarm builder, record request interpreter, publisher and beat sync
// assumes: APB master on core_clk; beat pin asynchronous to core_clk
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "dp_alarm_cfg.svh"

// Summary of operation
// - alarm octet one low six bits carry block length including octet zero
// - alarm octet one top two bits zero: device-related diagnosis
// - alarm type field in octet two equals one, diagnosis alarm
// - octet two top bit cleared, marking an alarm
// - octet three holds originating slot, zero for basic unit
// - octet four bits one..zero give coming or going specifier
// - octet four bit two zero, no extra acknowledgement
// - sequence field zero since only one alarm pends
// - exactly one detail byte at octet five
// - read gives short ack while busy, result once done
// - write to record zero or length not 68 gives 80 b8 00
// - extended function code not 8 gives 80 b6 00
// - read without earlier write gives 80 b5 00
// - invalid slot, index, record combination gives 80 b0 00
// - parameter octet seven bit seven enables publishing
// - publisher answers with broadcast receiver address
// - only publisher role, never subscriber
// - beat telegram realigns timebase within one microsecond
module dp_alarm_record (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link side events
   input wire logic beat_pin,
   output logic pub_broadcast,
   output logic alarm_pending,
   output logic beat_tick
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta_q, rst_n_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire sel_ctrl = paddr == `OFS_CTRL;
   wire sel_status = paddr == `OFS_STATUS;
   wire sel_src = paddr == `OFS_ALARM_SRC;
   wire sel_lo = paddr == `OFS_ALARM_LO;
   wire sel_hi = paddr == `OFS_ALARM_HI;
   wire sel_req = paddr == `OFS_REQ;
   wire sel_exec = paddr == `OFS_REQ_EXEC;
   wire sel_resp = paddr == `OFS_RESP;
   wire sel_sync = paddr == `OFS_SYNC;
   wire mapped = sel_ctrl | sel_status | sel_src | sel_lo | sel_hi | sel_req | sel_exec
                 | sel_resp | sel_sync;

   // ------------------------------------------------------------
   // control: publisher enable, alarm raise and acknowledge
   // ------------------------------------------------------------
   logic pub_en_q;
   logic [7:0] src_slot_q, src_detail_q;
   logic [1:0] src_spec_q;
   // ctrl bit0 = parameter octet 7 bit 7 copy, bit1 = raise, bit2 = master ack
   wire raise_req = wr && sel_ctrl && pwdata[1];
   wire ack_req = wr && sel_ctrl && pwdata[2];
   logic pend_q;
   wire raise_ok = raise_req && !pend_q;

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         pub_en_q <= 1'b0;
         src_slot_q <= 8'h00;
         src_detail_q <= 8'h00;
         src_spec_q <= 2'h0;
      end else begin
         if (wr && sel_ctrl) pub_en_q <= pwdata[0];
         if (wr && sel_src && !pend_q) begin
            src_slot_q <= pwdata[7:0];
            src_spec_q <= pwdata[9:8];
            src_detail_q <= pwdata[23:16];
         end
      end
   end

   // set wins over a simultaneous acknowledge
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) pend_q <= 1'b0;
      else pend_q <= raise_ok ? 1'b1 : (ack_req ? 1'b0 : pend_q);
   end

   // ------------------------------------------------------------
   // alarm block build
   // ------------------------------------------------------------
   dp_alarm_pkg::alarm_block_t blk_q;
   dp_alarm_pkg::alarm_block_t blk_d;
   always_comb begin
      blk_d.header = 8'h00;
      blk_d.len_sel = {`ALARM_SEL_DEVICE, `ALARM_BLOCK_LEN};
      blk_d.type_id = {`ALARM_ID_ALARM, `ALARM_TYPE_DIAG};
      blk_d.slot = src_slot_q;
      blk_d.specifier = {`ALARM_SEQ_ZERO, 1'b0, src_spec_q};
      blk_d.detail = src_detail_q;
   end
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) blk_q <= '0;
      else if (raise_ok) blk_q <= blk_d;
   end

   // ------------------------------------------------------------
   // record request interpreter
   // ------------------------------------------------------------
   dp_alarm_pkg::rec_req_t req_q;
   dp_alarm_pkg::rec_state_t st_q, st_d;
   logic [23:0] err_q, err_d;
   logic [3:0] busy_cnt_q;
   logic [7:0] rec_sel_q;
   logic posted_q;

   // req reg: [7:0] slot [15:8] index [23:16] ext fn [31:24] record idx
   // exec reg: [7:0] length, bit8 = write (1) or read request (0)
   wire exec_w = wr && sel_exec;
   wire [7:0] x_slot = req_q.slot;
   wire [7:0] x_index = req_q.index;
   wire [7:0] x_fn = req_q.ext_fn;
   wire [7:0] x_rec = req_q.rec_idx;
   wire [7:0] x_len = pwdata[7:0];
   wire x_write = pwdata[8];
   wire bad_addr = x_slot != `IDENT_SLOT || x_index != `IDENT_INDEX
                   || x_rec > `IDENT_MAX_REC;
   wire bad_fn = x_fn != `IDENT_EXT_FN;
   wire bad_len = x_write && (x_rec == 8'h00 || x_len != `IDENT_WR_LEN);
   // fetch only if setup latched a final answer: a short-ack read must not
   // throw away a result that completed between setup and access
   wire resp_rd = rd && sel_resp && !prdata[30];

   always_comb begin
      st_d = st_q;
      err_d = err_q;
      case (st_q)
         dp_alarm_pkg::REC_IDLE: begin
            if (exec_w) begin
               if (bad_addr) begin
                  st_d = dp_alarm_pkg::REC_ERR;
                  err_d = `ERR_BAD_ADDR;
               end else if (bad_fn) begin
                  st_d = dp_alarm_pkg::REC_ERR;
                  err_d = `ERR_EXT_FN;
               end else if (bad_len) begin
                  st_d = dp_alarm_pkg::REC_ERR;
                  err_d = `ERR_WRITE_LEN;
               end else begin
                  st_d = dp_alarm_pkg::REC_BUSY;
                  err_d = 24'h000000;
               end
            end
         end
         dp_alarm_pkg::REC_BUSY: begin
            if (busy_cnt_q == 4'h1) st_d = dp_alarm_pkg::REC_DONE;
         end
         dp_alarm_pkg::REC_DONE: begin
            if (resp_rd) st_d = dp_alarm_pkg::REC_IDLE;
         end
         dp_alarm_pkg::REC_ERR: begin
            if (resp_rd) st_d = dp_alarm_pkg::REC_IDLE;
         end
         default: st_d = dp_alarm_pkg::REC_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         st_q <= dp_alarm_pkg::REC_IDLE;
         err_q <= 24'h000000;
         busy_cnt_q <= 4'h0;
         req_q <= '0;
         rec_sel_q <= 8'h00;
         posted_q <= 1'b0;
      end else begin
         st_q <= st_d;
         err_q <= err_d;
         if (wr && sel_req && st_q == dp_alarm_pkg::REC_IDLE) begin
            req_q.slot <= pwdata[7:0];
            req_q.index <= pwdata[15:8];
            req_q.ext_fn <= pwdata[23:16];
            req_q.rec_idx <= pwdata[31:24];
         end
         if (exec_w && st_q == dp_alarm_pkg::REC_IDLE) begin
            req_q.length <= x_len;
            req_q.is_write <= x_write;
            rec_sel_q <= x_rec;
            busy_cnt_q <= `PROC_CYCLES;
         end else if (busy_cnt_q != 4'h0) begin
            busy_cnt_q <= busy_cnt_q - 4'h1;
         end
         // posted until the outcome has been fetched once
         if (exec_w && st_q == dp_alarm_pkg::REC_IDLE) posted_q <= 1'b1;
         else if (resp_rd && st_q != dp_alarm_pkg::REC_BUSY) posted_q <= 1'b0;
      end
   end

   // response word: [31] done, [30] short ack, [29] error, [23:0] code or record
   logic [31:0] resp_w;
   always_comb begin
      resp_w = 32'h00000000;
      if (!posted_q) resp_w = {8'h20, `ERR_NO_REQ};
      else if (st_q == dp_alarm_pkg::REC_BUSY) resp_w = 32'h40000000;
      else if (st_q == dp_alarm_pkg::REC_ERR) resp_w = {8'h20, err_q};
      else resp_w = {8'h80, 8'h00, req_q.length, rec_sel_q};
   end

   // ------------------------------------------------------------
   // beat synchroniser and timebase realign
   // ------------------------------------------------------------
   logic [2:0] beat_sync_q;
   logic beat_lvl_q;
   logic [15:0] tb_q;
   logic [15:0] period_q;
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         beat_sync_q <= 3'h0;
         beat_lvl_q <= 1'b0;
      end else begin
         beat_sync_q <= {beat_sync_q[1:0], beat_pin};
         if (beat_sync_q[1] == beat_sync_q[2]) beat_lvl_q <= beat_sync_q[2];
      end
   end
   wire beat_rise = beat_sync_q[1] == beat_sync_q[2] && beat_sync_q[2] && !beat_lvl_q;

   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         tb_q <= 16'h0000;
         period_q <= 16'h0000;
      end else if (beat_rise) begin
         tb_q <= 16'h0000;
         period_q <= tb_q;
      end else if (tb_q != 16'hffff) begin
         tb_q <= tb_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // outputs and apb read
   // ------------------------------------------------------------
   logic [31:0] rdata_d;
   always_comb begin
      rdata_d = 32'h00000000;
      if (sel_ctrl) rdata_d = {31'h0, pub_en_q};
      else if (sel_status) rdata_d = {24'h0, st_q, 2'h0, posted_q, pend_q};
      else if (sel_src) rdata_d = {8'h0, src_detail_q, 6'h0, src_spec_q, src_slot_q};
      else if (sel_lo) rdata_d = {blk_q.slot, blk_q.type_id, blk_q.len_sel, blk_q.header};
      else if (sel_hi) rdata_d = {16'h0, blk_q.detail, blk_q.specifier};
      else if (sel_req) rdata_d = {req_q.rec_idx, req_q.ext_fn, req_q.index, req_q.slot};
      else if (sel_resp) rdata_d = resp_w;
      else if (sel_sync) rdata_d = {period_q, tb_q};
   end

   // slave answers in the first access cycle; registered answer arrives next cycle
   logic ready_q;
   always_ff @(posedge core_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ready_q <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pub_broadcast <= 1'b0;
         alarm_pending <= 1'b0;
         beat_tick <= 1'b0;
      end else begin
         ready_q <= psel && !penable;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= !mapped;
         end
         pub_broadcast <= pub_en_q;
         alarm_pending <= pend_q;
         beat_tick <= beat_rise;
      end
   end
   assign pready = ready_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_alarm_hold;
      @(posedge core_clk) disable iff (!rst_n_q)
         pend_q && !ack_req |=> pend_q && $stable(blk_q);
   endproperty
   a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost before ack");

   property p_alarm_fields;
      @(posedge core_clk) disable iff (!rst_n_q)
         pend_q |-> blk_q.len_sel == 8'h06 && blk_q.type_id == 8'h01;
   endproperty
   a_alarm_fields: assert property (p_alarm_fields) else $error("alarm header wrong");

   property p_spec_bits;
      @(posedge core_clk) disable iff (!rst_n_q)
         pend_q |-> blk_q.specifier[7:2] == 6'h00;
   endproperty
   a_spec_bits: assert property (p_spec_bits) else $error("alarm octet four high bits set");

   property p_busy_ack;
      @(posedge core_clk) disable iff (!rst_n_q)
         st_q == dp_alarm_pkg::REC_BUSY |-> resp_w == 32'h40000000;
   endproperty
   a_busy_ack: assert property (p_busy_ack) else $error("busy read not short ack");

   property p_busy_len;
      @(posedge core_clk) disable iff (!rst_n_q)
         $rose(st_q == dp_alarm_pkg::REC_BUSY) |-> ##[7:8] st_q == dp_alarm_pkg::REC_DONE;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("processing time wrong");

   property p_no_req;
      @(posedge core_clk) disable iff (!rst_n_q)
         !posted_q |-> resp_w[23:0] == 24'h80b500;
   endproperty
   a_no_req: assert property (p_no_req) else $error("missing no-request code");

   property p_bad_fn;
      @(posedge core_clk) disable iff (!rst_n_q)
         exec_w && st_q == dp_alarm_pkg::REC_IDLE && !bad_addr && bad_fn
         |=> st_q == dp_alarm_pkg::REC_ERR && err_q == 24'h80b600;
   endproperty
   a_bad_fn: assert property (p_bad_fn) else $error("ext fn error code wrong");

   property p_bad_addr;
      @(posedge core_clk) disable iff (!rst_n_q)
         exec_w && st_q == dp_alarm_pkg::REC_IDLE && bad_addr |=> err_q == 24'h80b000;
   endproperty
   a_bad_addr: assert property (p_bad_addr) else $error("address error code wrong");

   property p_pub;
      @(posedge core_clk) disable iff (!rst_n_q)
         wr && sel_ctrl |-> ##2 pub_broadcast == $past(pwdata[0], 2);
   endproperty
   a_pub: assert property (p_pub) else $error("publisher enable not followed");

   property p_beat;
      @(posedge core_clk) disable iff (!rst_n_q)
         beat_rise |=> tb_q == 16'h0000;
   endproperty
   a_beat: assert property (p_beat) else $error("timebase not realigned");

endmodule : dp_alarm_record

// *** dp_beat_source.sv ***
// partner: clock beat telegram source standing in for the bus master
// assumes: bench sets enable and period; beat edges keep a fixed 1.3 ns phase offset to core_clk
`timescale 1ns/1ps
module dp_beat_source (
   // control from the bench
   input wire logic enable,
   input wire logic [15:0] period_cyc,
   // beat strobe toward the block
   output logic beat_pin,
   // master life counter, one step per cycle start
   output logic [15:0] life_cnt
);
   // ------------------------------------------------------------
   // beat generator
   // ------------------------------------------------------------
   // 1.3 ns offset keeps beat edges away from core_clk edges
   // gap after the strobe leaves room for acquisition and output offset
   initial begin
      beat_pin = 1'b0;
      life_cnt = 16'h0000;
      forever begin
         #1.3;
         if (enable) begin
            beat_pin = 1'b1;
            life_cnt = life_cnt + 16'h0001;
            #50.0;
            beat_pin = 1'b0;
            #(period_cyc * 5.0 - 51.3);
         end else begin
            #3.7;
         end
      end
   end
endmodule : dp_beat_source

// *** test_dp_alarm_record.sv ***
// testbench: alarm block, record requests, publisher flag, beat sync
// assumes: zero-wait apb slave; beat source model drives beat_pin
`timescale 1ns/1ps
`include "dp_alarm_cfg.svh"
module test_dp_alarm_record;
   logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
   logic beat_pin, pub_broadcast, alarm_pending, beat_tick, beat_en;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] beat_per, life;
   logic [7:0] slot, det;
   logic [1:0] spec;
   logic [47:0] cs [10];
   logic [23:0] cc [10];
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int ticks = 0;
   int rises = 0;

   dp_alarm_record uut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .beat_pin(beat_pin),
      .pub_broadcast(pub_broadcast), .alarm_pending(alarm_pending),
      .beat_tick(beat_tick));
   dp_beat_source partner (.enable(beat_en), .period_cyc(beat_per), .beat_pin(beat_pin),
      .life_cnt(life));

   // ------------------------------------------------------------
   // clock, timeout, monitors
   // ------------------------------------------------------------
   always #2.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         results();
      end
   end
   always @(posedge core_clk) if (beat_tick === 1'b1) ticks++;
   always @(posedge beat_pin) rises++;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // two idle edges after each transfer: no signal set twice at one edge,
   // and registered outputs have settled before the caller looks at them
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : apb

   function automatic logic [31:0] alarm_lo(input logic [7:0] s);
      return {s, 1'b0, 7'h01, 2'h0, 6'h06, 8'h00};
   endfunction : alarm_lo

   function automatic logic [31:0] alarm_hi(input logic [1:0] sp, input logic [7:0] d);
      return {16'h0, d, 5'h00, 1'b0, sp};
   endfunction : alarm_hi

   function automatic logic [31:0] resp(input logic [23:0] code, input logic [47:0] c);
      return (code == 24'h0) ? {16'h8000, c[15:8], c[23:16]} : {8'h20, code};
   endfunction : resp

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      beat_en = 1'b0;
      beat_per = 16'h0064;
      void'($urandom(32'hf051bb07));
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);

      chk("pending", 32'h0, {31'h0, alarm_pending});
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'h10, rd);
      apb(1'b0, `OFS_RESP, 32'h0);
      chk("resp no post", 32'h2080b500, rd);
      apb(1'b0, 12'h024, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test reset done");

      apb(1'b1, `OFS_CTRL, 32'h1);
      chk("publisher", 32'h1, {31'h0, pub_broadcast});
      apb(1'b0, `OFS_CTRL, 32'h0);
      chk("ctrl rd", 32'h1, {31'h0, rd[0]});
      $display("test publisher done");

      // every specifier once, last one from the basic unit
      for (int s = 0; s < 4; s++) begin
         slot = (s == 3) ? 8'h00 : 8'($urandom);
         det = 8'($urandom);
         spec = 2'(s);
         apb(1'b1, `OFS_ALARM_SRC, {8'h0, det, 6'h0, spec, slot});
         apb(1'b1, `OFS_CTRL, 32'h3);
         chk("pending", 32'h1, {31'h0, alarm_pending});
         apb(1'b0, `OFS_ALARM_LO, 32'h0);
         chk("alarm lo", alarm_lo(slot), rd);
         apb(1'b0, `OFS_ALARM_HI, 32'h0);
         chk("alarm hi", alarm_hi(spec, det), rd);
         apb(1'b1, `OFS_ALARM_SRC, {8'h0, ~det, 6'h0, ~spec, ~slot});
         apb(1'b1, `OFS_CTRL, 32'h3);
         apb(1'b0, `OFS_ALARM_LO, 32'h0);
         chk("alarm held", alarm_lo(slot), rd);
         apb(1'b1, `OFS_CTRL, 32'h5);
         chk("acked", 32'h0, {31'h0, alarm_pending});
      end
      $display("test alarm done");

      // slot index fn rec len write, then expected code (zero when done)
      cs[0] = {8'h00, 8'hff, 8'h08, 8'h01, 8'h44, 8'h01};
      cs[1] = {8'h00, 8'hff, 8'h08, 8'h00, 8'($urandom), 8'h00};
      cs[2] = {8'h00, 8'hff, 8'h08, 8'h04, 8'h44, 8'h01};
      cs[3] = {8'h00, 8'hff, 8'h08, 8'h00, 8'h44, 8'h01};
      cs[4] = {8'h00, 8'hff, 8'h08, 8'h02, 8'h43, 8'h01};
      cs[5] = {8'h00, 8'hff, 8'h07, 8'h01, 8'h44, 8'h01};
      cs[6] = {8'h01, 8'hff, 8'h08, 8'h01, 8'h44, 8'h01};
      cs[7] = {8'h00, 8'hfe, 8'h08, 8'h01, 8'h44, 8'h01};
      cs[8] = {8'h00, 8'hff, 8'h08, 8'h05, 8'h44, 8'h01};
      cs[9] = {8'h00, 8'hff, 8'h10 | 8'($urandom % 8), 8'h00, 8'h44, 8'h01};
      cc = '{24'h0, 24'h0, 24'h0, 24'h80b800, 24'h80b800, 24'h80b600,
             24'h80b000, 24'h80b000, 24'h80b000, 24'h80b600};
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, `OFS_REQ, {cs[i][23:16], cs[i][31:24], cs[i][39:32], cs[i][47:40]});
         apb(1'b1, `OFS_REQ_EXEC, {23'h0, cs[i][0], cs[i][15:8]});
         apb(1'b0, `OFS_RESP, 32'h0);
         chk("resp first", (cc[i] == 24'h0) ? 32'h40000000 : resp(cc[i], cs[i]), rd);
         while (rd === 32'h40000000) apb(1'b0, `OFS_RESP, 32'h0);
         chk("resp", resp(cc[i], cs[i]), rd);
      end
      $display("test record done");

      beat_per = 16'(40 + $urandom % 80);
      rises = 0;
      ticks = 0;
      beat_en <= 1'b1;
      repeat (beat_per * 4 + 20) @(posedge core_clk);
      beat_en <= 1'b0;
      repeat (beat_per + 20) @(posedge core_clk);
      chk("beat ticks", 32'(rises), 32'(ticks));
      chk("life count", 32'(ticks), 32'(life));
      apb(1'b0, `OFS_SYNC, 32'h0);
      chk("beat period", 32'(beat_per), (rd[31:16] + 16'h1 >= beat_per &&
          rd[31:16] <= beat_per + 16'h1) ? 32'(beat_per) : 32'(rd[31:16]));
      chk("publisher kept", 32'h1, {31'h0, pub_broadcast});
      $display("test beat done");
      results();
   end
endmodule : test_dp_alarm_record
